// *** pkg/sscs_defs.vh ***
// Register map, field positions, reset values and timing for the strap and config sequencer
// How it works
// - Both supply monitors good starts an internal reset pulse of 75 ns rounded up to one 100 ns clock.
// - The internal power-up pulse does not depend on the external reset pin.
// - Multifunction pins are high-impedance inputs within 45 ns of the pulse.
// - Pins float during either reset; release captures them into the strap word.
// - Strap word bit n holds the captured level of multifunction pin n.
// - Strap bits 2:0 zero select SPI, else I2C with those address bits.
// - Upper strap bits zero: no EEPROM load, registers take their defaults.
// - Upper strap bits nonzero: EEPROM loads registers with them as condition.
// - Writing update bit 0 applies system clock settings; host issues it.
// - After reset every multifunction pin is an unassigned floating input.
// - Interrupt mask resets to block all; pin mode resets to open-drain.
// - Watchdog timer is disabled after reset until software enables it.
// - Every distribution output enable resets to disabled.
// - Update applying all settings starts acquisition of best reference.
// - Auto profiles: detect register picks machines, started by an update.
// - Set then clear the sync bit to start the distribution outputs.
`ifndef SSCS_DEFS_VH
`define SSCS_DEFS_VH

`define SSCS_ADDR_W        13
`define SSCS_REG_UPDATE    13'h0005
`define SSCS_REG_SYSTEM_CLOCK_INPUT    13'h0100
`define SSCS_REG_IRQ_MODE  13'h0208
`define SSCS_REG_IRQ_MASK  13'h020A
`define SSCS_REG_WDOG      13'h0211
`define SSCS_REG_OUT_EN    13'h0401
`define SSCS_REG_SYNC_CAL  13'h0A02
`define SSCS_REG_DETECT    13'h0A0D
`define SSCS_REG_STRAP     13'h0D01
`define SSCS_REG_STATUS    13'h0D02

`define SSCS_BIT_UPDATE    0
`define SSCS_BIT_CAL       0
`define SSCS_BIT_SYNC      1
`define SSCS_BIT_OPEN_DR   0
`define SSCS_BIT_WDOG_EN   0

`define SSCS_RST_SYSTEM_CLOCK_INPUT    8'h00
`define SSCS_RST_IRQ_MODE  8'h01
`define SSCS_RST_IRQ_MASK  8'hFF
`define SSCS_RST_WDOG      8'h00
`define SSCS_RST_OUT_EN    8'h00
`define SSCS_RST_SYNC_CAL  8'h00
`define SSCS_RST_DETECT    8'h00

`define SSCS_CLK_PERIOD_NS 100
`define SSCS_POR_PULSE_NS  75
`define SSCS_PIN_FLOAT_NS  45
`define SSCS_SPI_INST_BITS 16
`define SSCS_SPI_ALL_BITS  24

`endif

// *** test/sscs_host_model.sv ***
// Host serial port master for the sequencer
`timescale 1ns/100ps
module sscs_host_model (
  input  wire i_mclk,
  input  wire i_spi_sdo,
  output reg  o_sclk,
  output reg  o_csb_n,
  output reg  o_sdi
);
  initial begin
    o_sclk = 1'b0;
    o_csb_n = 1'b1;
    o_sdi = 1'b0;
  end
  // One 24-bit frame, MSB first, 800 ns a bit
  task xfer(input [23:0] frame, output [7:0] rd);
    integer i;
    begin
      rd = 8'h00;
      @(posedge i_mclk);
      o_csb_n <= 1'b0;
      for (i = 0; i <= 24; i = i + 1) begin
        repeat (4) @(posedge i_mclk);
        if (i >= 17)
          rd = {rd[6:0], i_spi_sdo};
        o_sclk <= 1'b0;
        if (i < 24)
          o_sdi <= frame[23-i];
        repeat (4) @(posedge i_mclk);
        if (i < 24)
          o_sclk <= 1'b1;
      end
      o_csb_n <= 1'b1;
      o_sdi <= ~o_sdi;
      repeat (8) @(posedge i_mclk);
    end
  endtask
endmodule // sscs_host_model

// *** test/sscs_props_properties.sv ***
// Port assertions for the strap and config sequencer
`timescale 1ns/100ps
module sscs_props (
  input wire       i_mclk,
  input wire       i_rst_n,
  input wire       i_dvdd_ok,
  input wire       i_reset_pin,
  input wire [7:0] o_mf_out,
  input wire [7:0] o_mf_oe_n,
  input wire       o_dev_reset,
  input wire [7:0] o_strap_word,
  input wire       o_i2c_sel,
  input wire [2:0] o_i2c_addr_lsb,
  input wire       o_eeprom_load,
  input wire [4:0] o_eeprom_cond,
  input wire       o_defaults_load,
  input wire [7:0] o_system_clock_input_cfg,
  input wire       o_cal_start,
  input wire       o_dist_sync,
  input wire [7:0] o_detect_start,
  input wire       o_acquire,
  input wire [7:0] o_irq_mask,
  input wire       o_irq_open_drain,
  input wire       o_wdog_en,
  input wire [3:0] o_out_en
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  a_pins_float: assert property (
    o_mf_oe_n == 8'hFF && o_mf_out == 8'h00) else $error("pins driven");
  a_por_pulse: assert property (
    $rose(i_dvdd_ok) && !i_reset_pin |-> ##[2:6] o_dev_reset ##1 !o_dev_reset)
    else $error("no power-up pulse");
  a_load_once: assert property (
    $fell(o_dev_reset) |-> o_eeprom_load ^ o_defaults_load) else $error("no load pulse");
  a_eeprom_cond: assert property (
    o_eeprom_load |-> o_strap_word[7:3] != 5'h00 && o_eeprom_cond == o_strap_word[7:3])
    else $error("bad eeprom load");
  a_defaults_cond: assert property (
    o_defaults_load |-> o_strap_word[7:3] == 5'h00) else $error("bad defaults load");
  a_mode_select: assert property (
    !o_dev_reset && !$past(o_dev_reset) |-> o_i2c_sel == (o_strap_word[2:0] != 3'h0)
    && o_i2c_addr_lsb == o_strap_word[2:0]) else $error("bad port mode");
  a_reset_defaults: assert property (
    o_dev_reset |=> o_irq_mask == 8'hFF && o_irq_open_drain && !o_wdog_en
    && o_out_en == 4'h0) else $error("bad reset defaults");
  a_buffered_cfg: assert property (
    $changed(o_system_clock_input_cfg) |-> o_acquire || o_dev_reset)
    else $error("config changed without update");
  a_pulse_on_update: assert property (
    o_cal_start || o_dist_sync || o_detect_start != 8'h00 |-> o_acquire)
    else $error("pulse without update");
endmodule // sscs_props

bind sscs_sequencer sscs_props sscs_props_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_dvdd_ok(i_dvdd_ok), .i_reset_pin(i_reset_pin), .o_mf_out(o_mf_out),
  .o_mf_oe_n(o_mf_oe_n), .o_dev_reset(o_dev_reset), .o_strap_word(o_strap_word),
  .o_i2c_sel(o_i2c_sel), .o_i2c_addr_lsb(o_i2c_addr_lsb), .o_eeprom_load(o_eeprom_load),
  .o_eeprom_cond(o_eeprom_cond), .o_defaults_load(o_defaults_load),
  .o_system_clock_input_cfg(o_system_clock_input_cfg), .o_cal_start(o_cal_start), .o_dist_sync(o_dist_sync),
  .o_detect_start(o_detect_start), .o_acquire(o_acquire), .o_irq_mask(o_irq_mask),
  .o_irq_open_drain(o_irq_open_drain), .o_wdog_en(o_wdog_en), .o_out_en(o_out_en));

// *** test/testbench.sv ***
// Self-checking bench for the strap and config sequencer
`timescale 1ns/100ps
`include "sscs_defs.vh"
module testbench;
  reg        i_mclk, i_rst_n, i_dvdd_ok, i_dvdd3_ok, i_reset_pin;
  reg  [7:0] i_mf_pin, det, rd;
  wire       sclk, csb_n, sdi, sdo, sdo_oe_n, dev_rst, sel, ee, df, cal, sync, acq, od, wd;
  wire [7:0] mf_out, mf_oe_n, strap, system_clock_input, detect, mask;
  wire [4:0] cond;
  wire [3:0] out_en;
  wire [2:0] addr;
  integer    errors, compares, n_acq, n_cal, n_sync, n_ee, n_df;
  sscs_sequencer sscs_sequencer_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_dvdd3_ok(i_dvdd3_ok),
    .i_dvdd_ok(i_dvdd_ok), .i_reset_pin(i_reset_pin), .i_mf_pin(i_mf_pin),
    .i_spi_sclk(sclk), .i_spi_csb_n(csb_n), .i_spi_sdi(sdi), .i_cal_done(1'b0),
    .o_mf_out(mf_out), .o_mf_oe_n(mf_oe_n), .o_spi_sdo(sdo), .o_spi_sdo_oe_n(sdo_oe_n),
    .o_dev_reset(dev_rst), .o_strap_word(strap), .o_i2c_sel(sel), .o_i2c_addr_lsb(addr),
    .o_eeprom_load(ee), .o_eeprom_cond(cond), .o_defaults_load(df), .o_system_clock_input_cfg(system_clock_input),
    .o_cal_start(cal), .o_dist_sync(sync), .o_detect_start(detect), .o_acquire(acq),
    .o_irq_mask(mask), .o_irq_open_drain(od), .o_wdog_en(wd), .o_out_en(out_en));
  sscs_host_model sscs_host_model_i (.i_mclk(i_mclk), .i_spi_sdo(sdo), .o_sclk(sclk),
    .o_csb_n(csb_n), .o_sdi(sdi));
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    n_acq += (acq === 1'b1);
    n_cal += (cal === 1'b1);
    n_sync += (sync === 1'b1);
    n_ee += (ee === 1'b1);
    n_df += (df === 1'b1);
    if (detect !== 8'h00)
      det = detect;
  end
  task check(input string what, input [63:0] seen, input [63:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("Error %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wr(input [12:0] a, input [7:0] d);
    sscs_host_model_i.xfer({3'b000, a, d}, rd);
  endtask
  task rdreg(input [12:0] a);
    sscs_host_model_i.xfer({3'b100, a, 8'h00}, rd);
  endtask
  task upd;
    wr(`SSCS_REG_UPDATE, 8'h01);
  endtask
  task boot;
    integer k;
    begin
      for (k = 0; k < 60 && dev_rst !== 1'b0; k = k + 1)
        @(posedge i_mclk);
      repeat (3) @(posedge i_mclk);
    end
  endtask
  task strap_chk(input [7:0] s, input integer e, input integer d);
    begin
      check("strap", strap, s);
      check("mode", {sel, addr}, {s[2:0] != 3'h0, s[2:0]});
      check("loads", {n_ee, n_df}, {e, d});
      if (s[7:3] != 5'h00)
        check("cond", cond, s[7:3]);
    end
  endtask
  task finish_test;
    begin
      $display("Compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #2_000_000;
    errors = errors + 1;
    finish_test;
  end
  initial begin
    {errors, compares, n_acq, n_cal, n_sync, n_ee, n_df} = 0;
    {i_rst_n, i_reset_pin, i_mf_pin, det} = 0;
    {i_dvdd_ok, i_dvdd3_ok} = 2'b11;
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    boot;
    strap_chk(8'h00, 0, 1);
    check("dflt", {mask, od, wd, out_en}, {8'hFF, 1'b1, 1'b0, 4'h0});
    check("oe_n", mf_oe_n, 8'hFF);
    rdreg(`SSCS_REG_IRQ_MASK);
    check("rd_mask", rd, `SSCS_RST_IRQ_MASK);
    check("sdo_oe_n", sdo_oe_n, 1'b1);
    rdreg(13'h0123);
    check("rd_unmapped", rd, 8'h00);
    wr(`SSCS_REG_SYSTEM_CLOCK_INPUT, 8'hA5);
    check("system_clock_input_buf", system_clock_input, 8'h00);
    rdreg(`SSCS_REG_SYSTEM_CLOCK_INPUT);
    check("rd_system_clock_input", rd, 8'hA5);
    upd;
    check("system_clock_input", {system_clock_input, n_acq}, {8'hA5, 32'd1});
    wr(`SSCS_REG_SYNC_CAL, 8'h01);
    upd;
    wr(`SSCS_REG_SYNC_CAL, 8'h00);
    upd;
    check("cal", n_cal, 1);
    wr(`SSCS_REG_SYNC_CAL, 8'h02);
    upd;
    check("sync_early", n_sync, 0);
    wr(`SSCS_REG_SYNC_CAL, 8'h00);
    upd;
    check("sync", {n_sync, n_cal}, {32'd1, 32'd1});
    wr(`SSCS_REG_WDOG, 8'h01);
    wr(`SSCS_REG_OUT_EN, 8'h0F);
    wr(`SSCS_REG_IRQ_MASK, 8'h00);
    wr(`SSCS_REG_DETECT, 8'h3C);
    upd;
    check("detect", {det, n_acq}, {8'h3C, 32'd6});
    check("cfg", {mask, wd, out_en}, {8'h00, 1'b1, 4'hF});
    i_mf_pin <= 8'hAB;
    i_reset_pin <= 1'b1;
    repeat (10) @(posedge i_mclk);
    check("pin_rst", dev_rst, 1'b1);
    i_reset_pin <= 1'b0;
    boot;
    strap_chk(8'hAB, 1, 1);
    check("rst_dflt", {mask, od, wd, out_en}, {8'hFF, 1'b1, 1'b0, 4'h0});
    i_mf_pin <= 8'h08;
    {i_dvdd_ok, i_dvdd3_ok} <= 2'b00;
    repeat (10) @(posedge i_mclk);
    i_dvdd3_ok <= 1'b1;
    repeat (8) @(posedge i_mclk);
    check("por_hold", {dev_rst, n_ee}, {1'b1, 32'd1});
    i_dvdd_ok <= 1'b1;
    repeat (8) @(posedge i_mclk);
    boot;
    strap_chk(8'h08, 2, 1);
    rdreg(`SSCS_REG_STRAP);
    check("rd_strap", rd, 8'h08);
    finish_test;
  end
endmodule // testbench

// *** verilog/sscs_sequencer.v ***
// Start-up strap capture, serial register port and update-driven config sequencer
`timescale 1ns/100ps
`include "sscs_defs.vh"
module sscs_sequencer (
  input  wire       i_mclk,
  input  wire       i_rst_n,
  input  wire       i_dvdd3_ok,
  input  wire       i_dvdd_ok,
  input  wire       i_reset_pin,
  input  wire [7:0] i_mf_pin,
  input  wire       i_spi_sclk,
  input  wire       i_spi_csb_n,
  input  wire       i_spi_sdi,
  input  wire       i_cal_done,
  output reg  [7:0] o_mf_out,
  output reg  [7:0] o_mf_oe_n,
  output reg        o_spi_sdo,
  output reg        o_spi_sdo_oe_n,
  output reg        o_dev_reset,
  output reg  [7:0] o_strap_word,
  output reg        o_i2c_sel,
  output reg  [2:0] o_i2c_addr_lsb,
  output reg        o_eeprom_load,
  output reg  [4:0] o_eeprom_cond,
  output reg        o_defaults_load,
  output reg  [7:0] o_system_clock_input_cfg,
  output reg        o_cal_start,
  output reg        o_dist_sync,
  output reg  [7:0] o_detect_start,
  output reg        o_acquire,
  output reg  [7:0] o_irq_mask,
  output reg        o_irq_open_drain,
  output reg        o_wdog_en,
  output reg  [3:0] o_out_en
);
  localparam POR_CYC_RAW = (`SSCS_POR_PULSE_NS + `SSCS_CLK_PERIOD_NS - 1) / `SSCS_CLK_PERIOD_NS;
  localparam POR_CYC     = (POR_CYC_RAW < 1) ? 1 : POR_CYC_RAW;
  localparam FLT_CYC_RAW = `SSCS_PIN_FLOAT_NS / `SSCS_CLK_PERIOD_NS;
  localparam FLT_CYC     = (FLT_CYC_RAW < 1) ? 1 : FLT_CYC_RAW;
  localparam [3:0] POR_LOAD = POR_CYC[3:0];

  wire        s_dvdd3;
  wire        s_dvdd;
  wire        s_rst_pin;
  wire [7:0]  s_mf;
  wire        s_sclk;
  wire        s_cs;
  wire        s_sdi;

  reg         supplies_q;
  reg  [3:0]  por_cnt;
  reg         rst_cond_q;
  reg         sclk_q;
  reg  [4:0]  bit_cnt;
  reg  [15:0] inst;
  reg  [7:0]  wdata;
  reg  [7:0]  rd_shift;
  reg         wr_pulse;
  reg  [12:0] wr_addr;
  reg  [7:0]  wr_data;
  reg         upd_pulse;
  reg         cal_busy;
  reg  [7:0]  b_system_clock_input;
  reg  [7:0]  b_irq_mode;
  reg  [7:0]  b_irq_mask;
  reg  [7:0]  b_wdog;
  reg  [7:0]  b_out_en;
  reg  [7:0]  b_sync_cal;
  reg  [7:0]  b_detect;
  reg  [7:0]  a_sync_cal;
  reg  [7:0]  rd_mux;

  wire        supplies_ok = s_dvdd3 & s_dvdd;
  wire        por_active  = (por_cnt != 4'h0);
  // Held while supplies are below threshold
  wire        rst_cond    = por_active | s_rst_pin | ~supplies_q;
  wire        rst_release = rst_cond_q & ~rst_cond;
  wire        spi_on      = s_cs & ~rst_cond & ~o_i2c_sel;
  wire        sclk_rise   = s_sclk & ~sclk_q;
  wire        sclk_fall   = ~s_sclk & sclk_q;
  wire [15:0] inst_next   = {inst[14:0], s_sdi};
  wire        rd_phase    = inst[15] & (bit_cnt >= 5'd16) & (bit_cnt < 5'd24);

  sscs_sync3 #(.W(5)) u_sync_ctl (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async ({i_dvdd3_ok, i_dvdd_ok, i_reset_pin, i_spi_sclk, i_spi_sdi}),
    .o_sync  ({s_dvdd3, s_dvdd, s_rst_pin, s_sclk, s_sdi})
  );

  // Select inverted so the reset value reads as deselected
  sscs_sync3 #(.W(9)) u_sync_pins (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async ({~i_spi_csb_n, i_mf_pin}),
    .o_sync  ({s_cs, s_mf})
  );

  // Power-up pulse from supplies only, reset pin combined afterwards
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      supplies_q  <= 1'b0;
      por_cnt     <= 4'h0;
      rst_cond_q  <= 1'b1;
      o_dev_reset <= 1'b1;
    end else begin
      supplies_q <= supplies_ok;
      if (supplies_ok && !supplies_q) begin
        por_cnt <= POR_LOAD;
      end else if (por_active) begin
        por_cnt <= por_cnt - 4'h1;
      end
      rst_cond_q  <= rst_cond;
      o_dev_reset <= rst_cond;
    end
  end

  // Pins stay floating inputs; no pin function is assigned here
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mf_oe_n <= 8'hFF;
      o_mf_out  <= 8'h00;
    end else begin
      o_mf_oe_n <= 8'hFF;
      o_mf_out  <= 8'h00;
    end
  end

  // Strap capture on release of reset
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_strap_word    <= 8'h00;
      o_i2c_sel       <= 1'b0;
      o_i2c_addr_lsb  <= 3'h0;
      o_eeprom_load   <= 1'b0;
      o_eeprom_cond   <= 5'h00;
      o_defaults_load <= 1'b0;
    end else begin
      o_eeprom_load   <= 1'b0;
      o_defaults_load <= 1'b0;
      if (rst_release) begin
        o_strap_word   <= s_mf;
        o_i2c_sel      <= (s_mf[2:0] != 3'h0);
        o_i2c_addr_lsb <= s_mf[2:0];
        o_eeprom_cond  <= s_mf[7:3];
        if (s_mf[7:3] != 5'h00) begin
          o_eeprom_load <= 1'b1;
        end else begin
          o_defaults_load <= 1'b1;
        end
      end
    end
  end

  // Read data selection by address
  always @* begin
    case (inst_next[12:0])
      `SSCS_REG_SYSTEM_CLOCK_INPUT:   rd_mux = b_system_clock_input;
      `SSCS_REG_IRQ_MODE: rd_mux = b_irq_mode;
      `SSCS_REG_IRQ_MASK: rd_mux = b_irq_mask;
      `SSCS_REG_WDOG:     rd_mux = b_wdog;
      `SSCS_REG_OUT_EN:   rd_mux = b_out_en;
      `SSCS_REG_SYNC_CAL: rd_mux = b_sync_cal;
      `SSCS_REG_DETECT:   rd_mux = b_detect;
      `SSCS_REG_STRAP:    rd_mux = o_strap_word;
      `SSCS_REG_STATUS:   rd_mux = {6'h00, cal_busy, o_i2c_sel};
      default:            rd_mux = 8'h00;
    endcase
  end

  // Serial port: 16-bit instruction then one data byte
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_q         <= 1'b0;
      bit_cnt        <= 5'h00;
      inst           <= 16'h0000;
      wdata          <= 8'h00;
      rd_shift       <= 8'h00;
      wr_pulse       <= 1'b0;
      wr_addr        <= 13'h0000;
      wr_data        <= 8'h00;
      o_spi_sdo      <= 1'b0;
      o_spi_sdo_oe_n <= 1'b1;
    end else begin
      sclk_q   <= s_sclk;
      wr_pulse <= 1'b0;
      if (!spi_on) begin
        bit_cnt        <= 5'h00;
        o_spi_sdo_oe_n <= 1'b1;
      end else begin
        o_spi_sdo_oe_n <= ~rd_phase;
        if (sclk_rise && bit_cnt < 5'd24) begin
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt < 5'd16) begin
            inst <= inst_next;
            if (bit_cnt == 5'd15) begin
              rd_shift <= rd_mux;
            end
          end else begin
            wdata <= {wdata[6:0], s_sdi};
            if (bit_cnt == 5'd23 && !inst[15]) begin
              wr_pulse <= 1'b1;
              wr_addr  <= inst[12:0];
              wr_data  <= {wdata[6:0], s_sdi};
            end
          end
        end
        if (sclk_fall && rd_phase) begin
          o_spi_sdo <= rd_shift[7];
          rd_shift  <= {rd_shift[6:0], 1'b0};
        end
      end
    end
  end

  // Buffered register copies, returned to their reset values while reset is held
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      b_system_clock_input   <= `SSCS_RST_SYSTEM_CLOCK_INPUT;
      b_irq_mode <= `SSCS_RST_IRQ_MODE;
      b_irq_mask <= `SSCS_RST_IRQ_MASK;
      b_wdog     <= `SSCS_RST_WDOG;
      b_out_en   <= `SSCS_RST_OUT_EN;
      b_sync_cal <= `SSCS_RST_SYNC_CAL;
      b_detect   <= `SSCS_RST_DETECT;
      upd_pulse  <= 1'b0;
    end else if (rst_cond) begin
      b_system_clock_input   <= `SSCS_RST_SYSTEM_CLOCK_INPUT;
      b_irq_mode <= `SSCS_RST_IRQ_MODE;
      b_irq_mask <= `SSCS_RST_IRQ_MASK;
      b_wdog     <= `SSCS_RST_WDOG;
      b_out_en   <= `SSCS_RST_OUT_EN;
      b_sync_cal <= `SSCS_RST_SYNC_CAL;
      b_detect   <= `SSCS_RST_DETECT;
      upd_pulse  <= 1'b0;
    end else begin
      upd_pulse <= 1'b0;
      if (wr_pulse) begin
        case (wr_addr)
          `SSCS_REG_UPDATE:   upd_pulse  <= wr_data[`SSCS_BIT_UPDATE];
          `SSCS_REG_SYSTEM_CLOCK_INPUT:   b_system_clock_input   <= wr_data;
          `SSCS_REG_IRQ_MODE: b_irq_mode <= {7'h00, wr_data[0]};
          `SSCS_REG_IRQ_MASK: b_irq_mask <= wr_data;
          `SSCS_REG_WDOG:     b_wdog     <= {7'h00, wr_data[0]};
          `SSCS_REG_OUT_EN:   b_out_en   <= {4'h0, wr_data[3:0]};
          `SSCS_REG_SYNC_CAL: b_sync_cal <= {6'h00, wr_data[1:0]};
          `SSCS_REG_DETECT:   b_detect   <= wr_data;
          default:            upd_pulse  <= 1'b0;
        endcase
      end
    end
  end

  // Active configuration, loaded only by an update
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_system_clock_input_cfg     <= `SSCS_RST_SYSTEM_CLOCK_INPUT;
      o_irq_open_drain <= 1'b1;
      o_irq_mask       <= `SSCS_RST_IRQ_MASK;
      o_wdog_en        <= 1'b0;
      o_out_en         <= 4'h0;
      a_sync_cal       <= `SSCS_RST_SYNC_CAL;
      o_cal_start      <= 1'b0;
      o_dist_sync      <= 1'b0;
      o_detect_start   <= 8'h00;
      o_acquire        <= 1'b0;
      cal_busy         <= 1'b0;
    end else if (rst_cond) begin
      o_system_clock_input_cfg     <= `SSCS_RST_SYSTEM_CLOCK_INPUT;
      o_irq_open_drain <= 1'b1;
      o_irq_mask       <= `SSCS_RST_IRQ_MASK;
      o_wdog_en        <= 1'b0;
      o_out_en         <= 4'h0;
      a_sync_cal       <= `SSCS_RST_SYNC_CAL;
      o_cal_start      <= 1'b0;
      o_dist_sync      <= 1'b0;
      o_detect_start   <= 8'h00;
      o_acquire        <= 1'b0;
      cal_busy         <= 1'b0;
    end else begin
      o_cal_start    <= 1'b0;
      o_dist_sync    <= 1'b0;
      o_detect_start <= 8'h00;
      o_acquire      <= 1'b0;
      if (upd_pulse) begin
        o_system_clock_input_cfg     <= b_system_clock_input;
        o_irq_open_drain <= b_irq_mode[`SSCS_BIT_OPEN_DR];
        o_irq_mask       <= b_irq_mask;
        o_wdog_en        <= b_wdog[`SSCS_BIT_WDOG_EN];
        o_out_en         <= b_out_en[3:0];
        a_sync_cal       <= b_sync_cal;
        o_cal_start      <= b_sync_cal[`SSCS_BIT_CAL] & ~a_sync_cal[`SSCS_BIT_CAL];
        o_dist_sync      <= a_sync_cal[`SSCS_BIT_SYNC] & ~b_sync_cal[`SSCS_BIT_SYNC];
        o_detect_start   <= b_detect;
        o_acquire        <= 1'b1;
      end
      if (upd_pulse && b_sync_cal[`SSCS_BIT_CAL] && !a_sync_cal[`SSCS_BIT_CAL]) begin
        cal_busy <= 1'b1;
      end else if (i_cal_done) begin
        cal_busy <= 1'b0;
      end
    end
  end
endmodule // sscs_sequencer

// *** verilog/sscs_sync3.v ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module sscs_sync3 #(
  parameter W = 1
) (
  input  wire         i_mclk,
  input  wire         i_rst_n,
  input  wire [W-1:0] i_async,
  output reg  [W-1:0] o_sync
);
  reg [W-1:0] st1;
  reg [W-1:0] st2;
  reg [W-1:0] st3;
  integer     k;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st1    <= {W{1'b0}};
      st2    <= {W{1'b0}};
      st3    <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else begin
      st1 <= i_async;
      st2 <= st1;
      st3 <= st2;
      for (k = 0; k < W; k = k + 1) begin
        if (st2[k] == st3[k]) begin
          o_sync[k] <= st3[k];
        end
      end
    end
  end
endmodule // sscs_sync3
